// File: hw/aot_defines.svh
// register offsets, field positions, reset values and fixed patterns of the output test block
// assumes it is included by its bare name from the design files
`ifndef AOT_DEFINES_SVH
`define AOT_DEFINES_SVH

`define AOT_ADDR_TEST 8'h0d
`define AOT_ADDR_SELF_TEST 8'h0e
`define AOT_ADDR_TRIM 8'h10
`define AOT_ADDR_OUTCFG 8'h14
`define AOT_ADDR_DRIVE 8'h15
`define AOT_ADDR_UP1_LO 8'h19
`define AOT_ADDR_UP1_HI 8'h1a
`define AOT_ADDR_UP2_LO 8'h1b
`define AOT_ADDR_UP2_HI 8'h1c

`define AOT_RST_TEST 8'h00
`define AOT_RST_SELF_TEST 8'h00
`define AOT_RST_TRIM 8'h00
`define AOT_RST_OUTCFG 8'h00
`define AOT_RST_DRIVE 8'h22
`define AOT_RST_UP 8'h00

// writable bit masks; open bits read as zero
`define AOT_MASK_SELF_TEST 8'h05
`define AOT_MASK_OUTCFG 8'hd7

// output test register fields
`define AOT_TEST_MODE_HI 3
`define AOT_TEST_SHORT_RST 4
`define AOT_TEST_LONG_RST 5
`define AOT_TEST_USER_LO 6
// self-test register fields
`define AOT_SELF_TEST_START 0
`define AOT_SELF_TEST_INIT 2
// output configuration fields
`define AOT_OUTCFG_INVERT 2
`define AOT_OUTCFG_DISABLE 4
`define AOT_OUTCFG_STD_LO 6

// output test mode codes
`define AOT_TM_OFF 4'h0
`define AOT_TM_MID 4'h1
`define AOT_TM_POS_FS 4'h2
`define AOT_TM_NEG_FS 4'h3
`define AOT_TM_CHECKER 4'h4
`define AOT_TM_LONG_PRS 4'h5
`define AOT_TM_SHORT_PRS 4'h6
`define AOT_TM_WORD_TOG 4'h7
`define AOT_TM_USER 4'h8
`define AOT_TM_BIT_TOG 4'h9
`define AOT_TM_SYNC 4'ha
`define AOT_TM_ONE_HIGH 4'hb
`define AOT_TM_MIXED 4'hc

// fixed pattern words, offset binary
`define AOT_PAT_MID 10'h200
`define AOT_PAT_POS_FS 10'h3ff
`define AOT_PAT_NEG_FS 10'h000
`define AOT_PAT_CHECK_A 10'h155
`define AOT_PAT_CHECK_B 10'h2aa
`define AOT_PAT_SYNC 10'h3e0
`define AOT_PAT_MIXED_A 10'h333
`define AOT_PAT_MIXED_B 10'h0f0
`define AOT_PAT_WALK_SEED 10'h001

// sequence generator orders and feedback taps
`define AOT_LONG_ORDER 23
`define AOT_LONG_TAP 18
`define AOT_SHORT_ORDER 9
`define AOT_SHORT_TAP 5

`endif

// File: hw/aot_pkg.sv
// types shared by the output test block
// assumes nothing beyond a SystemVerilog compiler
package aot_pkg;
  typedef logic [9:0] aot_word_t;
  typedef logic [7:0] aot_byte_t;
  // playback state of the user pattern modes
  typedef enum logic [1:0] {AOT_US_FIRST, AOT_US_SECOND, AOT_US_IDLE} aot_user_state_t;
endpackage

// File: hw/aot_prbs.sv
// fibonacci shift register for the pseudo-random test sequences
// assumes one shift per sample clock and a synchronous active-low reset
`timescale 1ns/100ps
module aot_prbs #(
  parameter int ORDER = 23,
  parameter int TAP = 18
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hold,
  output aot_pkg::aot_word_t word
);
  import aot_pkg::*;

  // an order below the word width keeps extra history bits above the order, so every output bit is driven
  localparam int WIDTH = (ORDER > $bits(aot_word_t)) ? ORDER : $bits(aot_word_t);

  logic [WIDTH-1:0] state_ff;
  logic [WIDTH-1:0] nxt_state;

  // held at the all-ones seed; an all-zero state would lock up
  always_comb begin
    if (hold) begin
      nxt_state = '1;
    end else begin
      nxt_state = {state_ff[WIDTH-2:0], state_ff[ORDER-1] ^ state_ff[TAP-1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign word = state_ff[9:0];
endmodule // aot_prbs

// File: hw/aot_top.sv
// output test pattern, format and drive configuration behind the parallel sample port
// assumes the serial control port decoder hands over byte writes and reads on the sample clock,
// and that converted samples arrive one per clock in offset binary
//
// Overview of operation
// - an output test code from 0001 to 1100 replaces converted samples by the chosen fixed or toggling pattern.
// - code 0101 sends the order-23 pseudo-random sequence and code 0110 the order-9 sequence.
// - bit 0 of the self-test register at 0x0e starts the self-test, and that register resets to zero.
// - the low two bits of the output configuration pick the sample encoding, offset binary at 00 and reset.
// - output configuration at 0x14 holds standard in 7:6, disable at 4, invert at 2, and resets to 0x00.
// - the drive register holds four two-bit stripe counts for clock and data at both supplies, reset 0x22.
// - user mode plays two sixteen-bit patterns from byte pairs 0x19/0x1a and 0x1b/0x1c, low byte first, reset zero.
`timescale 1ns/100ps
`include "aot_defines.svh"
module aot_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire aot_pkg::aot_byte_t reg_addr,
  input wire aot_pkg::aot_byte_t reg_wr_data,
  output aot_pkg::aot_byte_t reg_rd_data,
  input wire aot_pkg::aot_word_t sample_data,
  output aot_pkg::aot_word_t data_out,
  output logic data_out_en,
  output logic [1:0] output_standard,
  output logic [1:0] clock_drive_3v3,
  output logic [1:0] clock_drive_1v8,
  output logic [1:0] data_drive_3v3,
  output logic [1:0] data_drive_1v8,
  output aot_pkg::aot_byte_t offset_trim,
  output logic self_test_start,
  output logic self_test_init
);
  import aot_pkg::*;

  // offset binary to the selected encoding; 11 falls back to offset binary
  function automatic aot_word_t encode(input aot_word_t w, input logic [1:0] fmt);
    case (fmt)
      2'h1: encode = {~w[9], w[8:0]};
      2'h2: encode = w ^ {1'b0, w[9:1]};
      default: encode = w;
    endcase
  endfunction

  function automatic logic hit(input aot_byte_t addr, input aot_byte_t target);
    hit = reg_wr_en && (addr == target);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register file

  aot_byte_t test_ff, nxt_test;
  aot_byte_t self_test_ff, nxt_self_test;
  aot_byte_t trim_ff, nxt_trim;
  aot_byte_t outcfg_ff, nxt_outcfg;
  aot_byte_t drive_ff, nxt_drive;
  logic [15:0] up1_ff, nxt_up1;
  logic [15:0] up2_ff, nxt_up2;
  aot_byte_t rd_ff, nxt_rd;
  logic start_ff, nxt_start;

  // byte writes land one clock after the strobe
  always_comb begin
    nxt_test = test_ff;
    nxt_self_test = self_test_ff;
    nxt_trim = trim_ff;
    nxt_outcfg = outcfg_ff;
    nxt_drive = drive_ff;
    nxt_up1 = up1_ff;
    nxt_up2 = up2_ff;
    nxt_start = 1'b0;
    if (hit(reg_addr, `AOT_ADDR_TEST)) nxt_test = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_SELF_TEST)) begin
      nxt_self_test = reg_wr_data & `AOT_MASK_SELF_TEST;
      // only a 0 to 1 write starts a run, rewriting 1 does not retrigger
      nxt_start = reg_wr_data[`AOT_SELF_TEST_START] & ~self_test_ff[`AOT_SELF_TEST_START];
    end
    if (hit(reg_addr, `AOT_ADDR_TRIM)) nxt_trim = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_OUTCFG)) nxt_outcfg = reg_wr_data & `AOT_MASK_OUTCFG;
    if (hit(reg_addr, `AOT_ADDR_DRIVE)) nxt_drive = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_UP1_LO)) nxt_up1[7:0] = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_UP1_HI)) nxt_up1[15:8] = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_UP2_LO)) nxt_up2[7:0] = reg_wr_data;
    if (hit(reg_addr, `AOT_ADDR_UP2_HI)) nxt_up2[15:8] = reg_wr_data;
  end

  // read data is registered; unmapped offsets answer zero
  always_comb begin
    nxt_rd = rd_ff;
    if (reg_rd_en) begin
      case (reg_addr)
        `AOT_ADDR_TEST: nxt_rd = test_ff;
        `AOT_ADDR_SELF_TEST: nxt_rd = self_test_ff;
        `AOT_ADDR_TRIM: nxt_rd = trim_ff;
        `AOT_ADDR_OUTCFG: nxt_rd = outcfg_ff;
        `AOT_ADDR_DRIVE: nxt_rd = drive_ff;
        `AOT_ADDR_UP1_LO: nxt_rd = up1_ff[7:0];
        `AOT_ADDR_UP1_HI: nxt_rd = up1_ff[15:8];
        `AOT_ADDR_UP2_LO: nxt_rd = up2_ff[7:0];
        `AOT_ADDR_UP2_HI: nxt_rd = up2_ff[15:8];
        default: nxt_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      test_ff <= `AOT_RST_TEST;
      self_test_ff <= `AOT_RST_SELF_TEST;
      trim_ff <= `AOT_RST_TRIM;
      outcfg_ff <= `AOT_RST_OUTCFG;
      drive_ff <= `AOT_RST_DRIVE;
      up1_ff <= {`AOT_RST_UP, `AOT_RST_UP};
      up2_ff <= {`AOT_RST_UP, `AOT_RST_UP};
      rd_ff <= 8'h00;
      start_ff <= 1'b0;
    end else begin
      test_ff <= nxt_test;
      self_test_ff <= nxt_self_test;
      trim_ff <= nxt_trim;
      outcfg_ff <= nxt_outcfg;
      drive_ff <= nxt_drive;
      up1_ff <= nxt_up1;
      up2_ff <= nxt_up2;
      rd_ff <= nxt_rd;
      start_ff <= nxt_start;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pseudo-random generators

  aot_word_t long_word;
  aot_word_t short_word;

  aot_prbs #(.ORDER(`AOT_LONG_ORDER), .TAP(`AOT_LONG_TAP)) u_long (
    .clock(clock),
    .rst_n(rst_n),
    .hold(test_ff[`AOT_TEST_LONG_RST]),
    .word(long_word)
  );

  aot_prbs #(.ORDER(`AOT_SHORT_ORDER), .TAP(`AOT_SHORT_TAP)) u_short (
    .clock(clock),
    .rst_n(rst_n),
    .hold(test_ff[`AOT_TEST_SHORT_RST]),
    .word(short_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // toggle phase, walking one and user playback

  logic phase_ff, nxt_phase;
  aot_word_t walk_ff, nxt_walk;
  aot_user_state_t user_ff, nxt_user;
  logic [3:0] mode;
  logic [1:0] user_mode;

  assign mode = test_ff[`AOT_TEST_MODE_HI:0];
  assign user_mode = test_ff[7:`AOT_TEST_USER_LO];

  // playback restarts on any test register write so a once mode can be replayed
  always_comb begin
    nxt_phase = ~phase_ff;
    nxt_walk = {walk_ff[8:0], walk_ff[9]};
    nxt_user = user_ff;
    if (hit(reg_addr, `AOT_ADDR_TEST)) begin
      nxt_user = AOT_US_FIRST;
    end else if (mode == `AOT_TM_USER) begin
      case (user_ff)
        AOT_US_FIRST: begin
          if (user_mode[0]) nxt_user = AOT_US_SECOND;
          else if (user_mode[1]) nxt_user = AOT_US_IDLE;
          else nxt_user = AOT_US_FIRST;
        end
        AOT_US_SECOND: nxt_user = user_mode[1] ? AOT_US_IDLE : AOT_US_FIRST;
        AOT_US_IDLE: nxt_user = AOT_US_IDLE;
        default: nxt_user = AOT_US_FIRST;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
      walk_ff <= `AOT_PAT_WALK_SEED;
      user_ff <= AOT_US_FIRST;
    end else begin
      phase_ff <= nxt_phase;
      walk_ff <= nxt_walk;
      user_ff <= nxt_user;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pattern select, format and output register

  aot_word_t pattern;
  aot_word_t nxt_data, data_ff;
  logic en_ff, nxt_en;

  // user patterns are sixteen bits wide; the ten-bit port carries the top bits
  always_comb begin
    case (mode)
      `AOT_TM_OFF: pattern = sample_data;
      `AOT_TM_MID: pattern = `AOT_PAT_MID;
      `AOT_TM_POS_FS: pattern = `AOT_PAT_POS_FS;
      `AOT_TM_NEG_FS: pattern = `AOT_PAT_NEG_FS;
      `AOT_TM_CHECKER: pattern = phase_ff ? `AOT_PAT_CHECK_B : `AOT_PAT_CHECK_A;
      `AOT_TM_LONG_PRS: pattern = long_word;
      `AOT_TM_SHORT_PRS: pattern = short_word;
      `AOT_TM_WORD_TOG: pattern = phase_ff ? `AOT_PAT_POS_FS : `AOT_PAT_NEG_FS;
      `AOT_TM_USER: begin
        case (user_ff)
          AOT_US_FIRST: pattern = up1_ff[15:6];
          AOT_US_SECOND: pattern = up2_ff[15:6];
          default: pattern = `AOT_PAT_NEG_FS;
        endcase
      end
      `AOT_TM_BIT_TOG: pattern = `AOT_PAT_CHECK_B;
      `AOT_TM_SYNC: pattern = `AOT_PAT_SYNC;
      `AOT_TM_ONE_HIGH: pattern = walk_ff;
      `AOT_TM_MIXED: pattern = phase_ff ? `AOT_PAT_MIXED_B : `AOT_PAT_MIXED_A;
      default: pattern = sample_data;
    endcase
    // invert acts after the format so it also covers the test patterns
    nxt_data = encode(pattern, outcfg_ff[1:0]) ^ {10{outcfg_ff[`AOT_OUTCFG_INVERT]}};
    nxt_en = ~outcfg_ff[`AOT_OUTCFG_DISABLE];
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_ff <= 10'h000;
      en_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      en_ff <= nxt_en;
    end
  end

  assign data_out = data_ff;
  assign data_out_en = en_ff;
  assign reg_rd_data = rd_ff;
  assign output_standard = outcfg_ff[7:`AOT_OUTCFG_STD_LO];
  assign clock_drive_3v3 = drive_ff[7:6];
  assign clock_drive_1v8 = drive_ff[5:4];
  assign data_drive_3v3 = drive_ff[3:2];
  assign data_drive_1v8 = drive_ff[1:0];
  assign offset_trim = trim_ff;
  assign self_test_start = start_ff;
  assign self_test_init = self_test_ff[`AOT_SELF_TEST_INIT];
endmodule // aot_top

// File: test/aot_capture.sv
// capture model of the logic that receives the parallel sample port
// assumes words change on the rising sample clock edge
`timescale 1ns/100ps
module aot_capture (
  input wire logic clock,
  input wire aot_pkg::aot_word_t data_in,
  input wire logic data_en,
  output aot_pkg::aot_word_t cap_word,
  output int cap_count
);
  import aot_pkg::*;
  // only an enabled port is sampled, a disabled one floats at the board
  initial begin
    cap_count = 0;
    forever @(posedge clock) begin
      if (data_en) begin
        cap_word <= data_in;
        cap_count <= cap_count + 1;
      end
    end
  end
endmodule // aot_capture

// File: test/aot_top_properties.sv
// port checker for the output test block
// assumes it is bound onto aot_top and sees only its ports
`timescale 1ns/100ps
module aot_top_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire aot_pkg::aot_byte_t reg_addr,
  input wire aot_pkg::aot_byte_t reg_wr_data,
  input wire aot_pkg::aot_word_t sample_data,
  input wire aot_pkg::aot_word_t data_out,
  input wire logic data_out_en,
  input wire logic [1:0] output_standard,
  input wire logic [1:0] clock_drive_3v3,
  input wire logic [1:0] clock_drive_1v8,
  input wire logic [1:0] data_drive_3v3,
  input wire logic [1:0] data_drive_1v8,
  input wire logic self_test_start
);
  import aot_pkg::*;
  aot_byte_t tm_ff, cfg_ff, drv_ff, st_ff, nxt_tm, nxt_cfg, nxt_drv, nxt_st;
  logic start_req;
  // shadow copies of the registers that steer the outputs
  always_comb begin
    nxt_tm = (reg_wr_en && reg_addr == 8'h0d) ? reg_wr_data : tm_ff;
    nxt_cfg = (reg_wr_en && reg_addr == 8'h14) ? reg_wr_data & 8'hd7 : cfg_ff;
    nxt_drv = (reg_wr_en && reg_addr == 8'h15) ? reg_wr_data : drv_ff;
    nxt_st = (reg_wr_en && reg_addr == 8'h0e) ? reg_wr_data & 8'h05 : st_ff;
    start_req = reg_wr_en && reg_addr == 8'h0e && reg_wr_data[0] && !st_ff[0];
  end
  always_ff @(posedge clock) begin
    {tm_ff, cfg_ff, drv_ff, st_ff} <= rst_n ? {nxt_tm, nxt_cfg, nxt_drv, nxt_st} : 32'h00002200;
  end
  ////////////////////////////////////////
  // data words trail the registers by one cycle, so causes are taken through $past
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  pass_through_a: assert property ($past(rst_n) && $past(tm_ff[3:0]) == 4'h0
    && $past(cfg_ff[2:0]) == 3'h0 |-> data_out == $past(sample_data)) else $error("sample path wrong");
  fixed_level_a: assert property ($past(rst_n) && $past(tm_ff[3:0]) inside {4'h1, 4'h2}
    && $past(cfg_ff[2:0]) == 3'h0 |-> data_out == ($past(tm_ff[0]) ? 10'h200 : 10'h3ff)) else $error("level wrong");
  seq_shift_a: assert property ($past(rst_n, 2) && $past(rst_n) && $past(tm_ff[3:0]) inside {4'h5, 4'h6}
    && $past(tm_ff[3:0], 2) == $past(tm_ff[3:0]) && $past(tm_ff[5:4], 2) == 2'h0 && $past(cfg_ff[2:0]) == 3'h0
    && $past(cfg_ff[2:0], 2) == 3'h0 |-> data_out[8:1] == $past(data_out[7:0])) else $error("sequence stuck");
  seed_hold_a: assert property ($past(rst_n) && $past(tm_ff[3:0]) == 4'h5 && $past(tm_ff[5], 2)
    && $past(cfg_ff[2:0]) == 3'h0 |-> data_out == 10'h3ff) else $error("long sequence not at seed");
  drive_map_a: assert property ({clock_drive_3v3, clock_drive_1v8, data_drive_3v3, data_drive_1v8} == drv_ff)
    else $error("drive fields wrong");
  standard_map_a: assert property (output_standard == cfg_ff[7:6]) else $error("standard wrong");
  enable_follow_a: assert property ($past(rst_n) |-> data_out_en == !$past(cfg_ff[4])) else $error("enable wrong");
  start_pulse_a: assert property ($past(rst_n) |-> self_test_start == $past(start_req)) else $error("start wrong");
  cover property (self_test_start);
  cover property ($past(tm_ff[3:0]) == 4'h8 && data_out == 10'h2af);
  cover property (!data_out_en);
endmodule // aot_top_properties
bind aot_top aot_top_properties u_aot_top_properties (.clock, .rst_n, .reg_wr_en, .reg_addr, .reg_wr_data,
  .sample_data, .data_out, .data_out_en, .output_standard, .clock_drive_3v3, .clock_drive_1v8,
  .data_drive_3v3, .data_drive_1v8, .self_test_start);

// File: test/adc_output_test_and_format_test.sv
// self-checking bench for the output test block
// assumes the capture model and the bound checker are compiled first
`timescale 1ns/100ps
module adc_output_test_and_format_test;
  import aot_pkg::*;
  logic clock, data_out_en, self_test_start, self_test_init;
  logic rst_n = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0;
  logic [1:0] output_standard, clock_drive_3v3, clock_drive_1v8, data_drive_3v3, data_drive_1v8;
  aot_byte_t reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, offset_trim;
  aot_word_t sample_data = 10'h123, data_out, cap_word, prev;
  int errors = 0, n_tests = 0, cap_count, hits;
  aot_top u_aot_top (.clock, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .sample_data,
    .data_out, .data_out_en, .output_standard, .clock_drive_3v3, .clock_drive_1v8, .data_drive_3v3,
    .data_drive_1v8, .offset_trim, .self_test_start, .self_test_init);
  aot_capture u_aot_capture (.clock, .data_in(data_out), .data_en(data_out_en), .cap_word, .cap_count);
  // 200 MHz sample clock
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  // compare, count and report
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // byte strobes are held across one rising edge, driven from the falling edge
  task automatic wr(aot_byte_t a, aot_byte_t d);
    @(negedge clock);
    reg_wr_en = 1'h1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge clock);
    reg_wr_en = 1'h0;
  endtask
  task automatic rd(aot_byte_t a, aot_byte_t exp);
    @(negedge clock);
    reg_rd_en = 1'h1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'h0;
    chk("readback", reg_rd_data, exp);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // reset values, an unmapped place, open bits, drive and disable
  task automatic t_regs();
    aot_byte_t a[8] = '{8'h0d, 8'h0e, 8'h10, 8'h14, 8'h15, 8'h19, 8'h1c, 8'h20};
    foreach (a[i]) rd(a[i], (a[i] == 8'h15) ? 8'h22 : 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'hd7);
    wr(8'h15, 8'h1b);
    chk("drive", {clock_drive_3v3, clock_drive_1v8, data_drive_3v3, data_drive_1v8}, 8'h1b);
    wr(8'h14, 8'h90);
    hits = cap_count;
    repeat (3) @(negedge clock);
    chk("standard", output_standard, 2'h2);
    chk("enable", data_out_en, 1'h0);
    chk("captures", cap_count - hits, 0);
    wr(8'h10, 8'h5a);
    chk("trim", offset_trim, 8'h5a);
  endtask
  // fixed codes under formats 00, 01 and 10 and under invert, and the sample path under formats 01 and 10
  task automatic t_fixed();
    logic [25:0] v[10] = '{{8'h0, 8'h1, 10'h200}, {8'h0, 8'h2, 10'h3ff}, {8'h0, 8'h3, 10'h000},
      {8'h1, 8'h1, 10'h000}, {8'h4, 8'h1, 10'h1ff}, {8'h2, 8'h2, 10'h200}, {8'h1, 8'h0, 10'h323},
      {8'h2, 8'h0, 10'h1b2}, {8'h0, 8'h9, 10'h2aa}, {8'h0, 8'ha, 10'h3e0}};
    foreach (v[i]) begin
      wr(8'h14, v[i][25:18]);
      wr(8'h0d, v[i][17:10]);
      repeat (2) @(negedge clock);
      chk("pattern", cap_word, v[i][9:0]);
    end
  endtask
  // toggling codes flip between two words every sample
  task automatic t_toggle();
    logic [13:0] v[3] = '{{4'h4, 10'h3ff}, {4'h7, 10'h3ff}, {4'hc, 10'h3c3}};
    wr(8'h14, 8'h00);
    foreach (v[i]) begin
      wr(8'h0d, {4'h0, v[i][13:10]});
      repeat (3) begin
        @(negedge clock);
        prev = data_out;
        @(negedge clock);
        chk("toggle", data_out ^ prev, v[i][9:0]);
      end
    end
    // single high bit walks one place left every sample
    wr(8'h0d, 8'h0b);
    @(negedge clock);
    repeat (3) begin
      prev = data_out;
      @(negedge clock);
      chk("walk", data_out, {prev[8:0], prev[9]});
      chk("one high", $countones(data_out), 1);
    end
  endtask
  // each generator is held at its seed, then released to shift
  task automatic t_prs();
    aot_byte_t h[2] = '{8'h25, 8'h16};
    foreach (h[i]) begin
      wr(8'h0d, h[i]);
      repeat (2) @(negedge clock);
      chk("seed", data_out[8:0], 9'h1ff);
      wr(8'h0d, h[i] & 8'h0f);
      repeat (12) begin
        prev = data_out;
        @(negedge clock);
        chk("shift", data_out[8:1], prev[7:0]);
      end
      chk("moving", data_out[8:0] != 9'h1ff, 1);
    end
  endtask
  // two user words alternate, then a single pass ends in zero
  task automatic t_user();
    wr(8'h19, 8'hcd);
    wr(8'h1a, 8'hab);
    wr(8'h1b, 8'h34);
    wr(8'h1c, 8'h12);
    rd(8'h1a, 8'hab);
    wr(8'h0d, 8'h48);
    @(negedge clock);
    repeat (4) begin
      prev = data_out;
      @(negedge clock);
      chk("user pair", {prev, data_out} inside {20'habc48, 20'h122af}, 1);
    end
    wr(8'h0d, 8'h88);
    repeat (3) @(negedge clock);
    chk("user once", data_out, 10'h000);
  endtask
  // start pulses only on a rise of the start bit
  task automatic t_self();
    aot_byte_t d[4] = '{8'h01, 8'h01, 8'h00, 8'h05};
    int e[4] = '{1, 0, 0, 1};
    foreach (d[i]) begin
      wr(8'h0e, d[i]);
      // the pulse already stands when the write task returns
      hits = self_test_start;
      repeat (3) begin
        @(negedge clock);
        hits += self_test_start;
      end
      chk("start pulses", hits, e[i]);
    end
    chk("init", self_test_init, 1'h1);
  endtask
  ////////////////////////////////////////
  // main sequence, reset held for twelve cycles
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'h1;
    t_regs();
    t_fixed();
    t_toggle();
    t_prs();
    t_user();
    t_self();
    stop_test();
  end
  // the run needs well under a thousand cycles, so this only cuts a hang
  initial begin
    #20us;
    errors++;
    stop_test();
  end
endmodule // adc_output_test_and_format_test
